// *** hdl/scm_flag_bank.sv ***
// Purpose: Sticky pending flags with edge or level setting and write-one clear
// Assumes: Conditions synchronous to clk_sys
// Notes:   Positions outside the flag mask hold no flip-flop and read zero
`timescale 1ns/10ps
`default_nettype none
module scm_flag_bank (
    // Clock and reset
    input  wire logic   clk_sys,
    input  wire logic   sys_rst,
    // Flag carrier
    scm_flag_if.bank    fl
);
    logic [14:0] prev_ff;
    logic [14:0] set_v;

    genvar k;
    generate
        for (k = 0; k < scm_pkg::SCM_NFLAG; k++)
        begin : g_flag
            if (scm_pkg::SCM_FLAG_MASK[k])
            begin : g_used
                logic flag_ff;
                // Edge mode fires once per rise; level mode refires after a clear
                assign set_v[k] = fl.level_sel[k] ? fl.cond[k]
                                                  : (fl.cond[k] & ~prev_ff[k]); // see [R17]
                always_ff @(posedge clk_sys or posedge sys_rst)
                begin
                    if (sys_rst)
                        prev_ff[k] <= 1'b0;
                    else
                        prev_ff[k] <= fl.cond[k];
                end
                // Set beats a clear arriving in the same cycle
                always_ff @(posedge clk_sys or posedge sys_rst)
                begin
                    if (sys_rst)
                        flag_ff <= scm_pkg::SCM_PEND_RST[k];
                    else
                        flag_ff <= (flag_ff & ~fl.clr[k]) | set_v[k]; // see [R16]
                end
                assign fl.flag[k] = flag_ff;
            end
            else
            begin : g_unused
                assign set_v[k]   = 1'b0;
                assign prev_ff[k] = 1'b0;
                assign fl.flag[k] = 1'b0;
            end
        end
    endgenerate

    set_wins_a: assert property ( // see [R16]
        @(posedge clk_sys) disable iff (sys_rst)
        (set_v[0] && fl.clr[0]) |=> fl.flag[0])
        else $error("clear beat a same-cycle set");

    clear_one_a: assert property ( // see [R16]
        @(posedge clk_sys) disable iff (sys_rst)
        (fl.clr[3] && !set_v[3]) |=> !fl.flag[3])
        else $error("write-one clear did not clear flag");

    edge_once_a: assert property ( // see [R17]
        @(posedge clk_sys) disable iff (sys_rst)
        (!fl.level_sel[1] && fl.cond[1] && $past(fl.cond[1]) && fl.clr[1])
        |=> !fl.flag[1])
        else $error("edge flag refired on steady condition");
endmodule
`default_nettype wire

// *** hdl/scm_flag_if.sv ***
// Purpose: Carries flag conditions, trigger kind and clears to the flag bank
// Assumes: One bit per flag position, unused positions ignored
// Notes:   Level select high means the condition sets the flag every cycle
`timescale 1ns/10ps
`default_nettype none
interface scm_flag_if;
    logic [14:0] cond;
    logic [14:0] level_sel;
    logic [14:0] clr;
    logic [14:0] flag;
    modport bank (input cond, input level_sel, input clr, output flag);
    modport ctrl (output cond, output level_sel, output clr, input flag);
endinterface
`default_nettype wire

// *** hdl/scm_pkg.sv ***
// Purpose: Shared constants for the serial mode and interrupt block
// Assumes: 32-bit register port, byte addresses as printed
// Notes:   Flag positions are shared by pending and enable registers
package scm_pkg;
    // Register byte addresses
    localparam logic [31:0] SCM_PEND_ADDR = 32'h4000a808;
    localparam logic [31:0] SCM_EN_ADDR   = 32'h4000a848;
    localparam logic [31:0] SCM_TRIG_ADDR = 32'h4000a854;
    localparam logic [31:0] SCM_MODE_ADDR = 32'h4000c854;
    localparam logic [31:0] SCM_FLOW_ADDR = 32'h4000c858;

    // Flag field layout
    localparam int          SCM_NFLAG      = 15;
    localparam logic [14:0] SCM_FLAG_MASK  = 15'h7e1f;
    localparam int          SCM_BIT_PARITY = 14;
    localparam int          SCM_BIT_FRAME  = 13;
    localparam int          SCM_BIT_TXB    = 12;
    localparam int          SCM_BIT_TXA    = 11;
    localparam int          SCM_BIT_RXB    = 10;
    localparam int          SCM_BIT_RXA    = 9;
    localparam int          SCM_BIT_UNDER  = 4;
    localparam int          SCM_BIT_OVER   = 3;
    localparam int          SCM_BIT_QUIET  = 2;
    localparam int          SCM_BIT_SPACE  = 1;
    localparam int          SCM_BIT_RXBYTE = 0;

    // Trigger select and mode fields
    localparam int          SCM_TRIG_W     = 3;
    localparam int          SCM_MODE_W     = 2;
    localparam logic [1:0]  SCM_MODE_OFF   = 2'h0;
    localparam logic [1:0]  SCM_MODE_UART  = 2'h1;
    localparam logic [1:0]  SCM_MODE_SPI   = 2'h2;
    localparam int          SCM_FLOW_BIT   = 0;

    // Values after reset
    localparam logic [14:0] SCM_PEND_RST   = 15'h0000;
    localparam logic [14:0] SCM_EN_RST     = 15'h0000;
    localparam logic [2:0]  SCM_TRIG_RST   = 3'h0;
    localparam logic [1:0]  SCM_MODE_RST   = 2'h0;
    localparam logic        SCM_FLOW_RST   = 1'h0;

    typedef enum logic [2:0] {
        SCM_SEL_NONE,
        SCM_SEL_PEND,
        SCM_SEL_EN,
        SCM_SEL_TRIG,
        SCM_SEL_MODE,
        SCM_SEL_FLOW
    } scm_sel_t;

    function automatic scm_sel_t scm_decode(input logic [31:0] addr);
        scm_sel_t sel;
        sel = SCM_SEL_NONE;
        if (addr == SCM_PEND_ADDR) sel = SCM_SEL_PEND;
        if (addr == SCM_EN_ADDR)   sel = SCM_SEL_EN;
        if (addr == SCM_TRIG_ADDR) sel = SCM_SEL_TRIG;
        if (addr == SCM_MODE_ADDR) sel = SCM_SEL_MODE;
        if (addr == SCM_FLOW_ADDR) sel = SCM_SEL_FLOW;
        return sel;
    endfunction
endpackage

// *** hdl/scm_serial_irq.sv ***
// Purpose: Mode select and second-level interrupt logic of the serial unit
// Assumes: Register port strobes one cycle wide, never together
// Notes:   Read data valid only in the cycle after the read strobe
//
// Contract
// [R1] Software sets mode parameters before enabling
// [R2] Software configures pins before enabling
// [R3] Software prepares DMA before writing mode
// [R4] Software picks trigger, enables, then top line
// [R5] Mode write is the final configuration step
// [R6] Two-bit mode: off, UART, SPI; resets zero
// [R7] Parity error bit 14, framing bit 13
// [R8] DMA buffer unloaded flags at bits 12..9
// [R9] Underrun bit 4, overrun bit 3
// [R10] Idle bit 2, space bit 1, data bit 0
// [R11] Enable bits gate flags onto interrupt line
// [R12] Receive-data flag edge or level by bit 0
// [R13] Transmit-space flag edge or level by bit 1
// [R14] Transmitter-idle flag edge or level by bit 2
// [R15] UART RTS/CTS only with flow control on
// [R16] Write one clears flag; set wins
// [R17] Edge sets once; level refires after clear
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module scm_serial_irq (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    // Register port
    input  wire logic [31:0] reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // Event pulses from the serial core and DMA
    input  wire logic        parity_fault_flag,
    input  wire logic        framing_fault_flag,
    input  wire logic        tx_dma_buf_b_done,
    input  wire logic        tx_dma_buf_a_done,
    input  wire logic        rx_dma_buf_b_done,
    input  wire logic        rx_dma_buf_a_done,
    input  wire logic        tx_underrun_flag,
    input  wire logic        rx_overrun_flag,
    // Level conditions from the serial core
    input  wire logic        tx_quiet_flag,
    input  wire logic        tx_space_flag,
    input  wire logic        rx_has_byte_flag,
    // Function select outputs
    output logic             uart_enable,
    output logic             spi_enable,
    // UART hardware flow control
    input  wire logic        uart_rts_req,
    input  wire logic        uart_cts_n_in,
    output logic             uart_rts_n_out,
    output logic             uart_rts_oe,
    output logic             uart_tx_permit,
    // Interrupt to the top-level controller
    output logic             serial_irq
);
    scm_flag_if fl ();

    scm_pkg::scm_sel_t sel;
    logic        wr_pend;
    logic        wr_en;
    logic        wr_trig;
    logic        wr_mode;
    logic        wr_flow;
    logic [14:0] en_ff;
    logic [2:0]  trig_ff;
    logic [1:0]  mode_ff;
    logic        flow_ff;
    logic [31:0] rd_mux;
    logic [31:0] rdata_ff;
    logic        irq_ff;
    logic        rts_n_ff;
    logic        rts_oe_ff;
    logic        flow_on;

    assign sel     = scm_pkg::scm_decode(reg_addr);
    assign wr_pend = reg_wr && (sel == scm_pkg::SCM_SEL_PEND);
    assign wr_en   = reg_wr && (sel == scm_pkg::SCM_SEL_EN);
    assign wr_trig = reg_wr && (sel == scm_pkg::SCM_SEL_TRIG);
    assign wr_mode = reg_wr && (sel == scm_pkg::SCM_SEL_MODE);
    assign wr_flow = reg_wr && (sel == scm_pkg::SCM_SEL_FLOW);

    // Flag sources in register bit order
    assign fl.cond = {parity_fault_flag, framing_fault_flag,    // see [R7]
                      tx_dma_buf_b_done, tx_dma_buf_a_done,
                      rx_dma_buf_b_done, rx_dma_buf_a_done,     // see [R8]
                      4'h0,
                      tx_underrun_flag, rx_overrun_flag,        // see [R9]
                      tx_quiet_flag, tx_space_flag,
                      rx_has_byte_flag};                        // see [R10]

    // Pulse sources are always level; the low three follow the trigger select
    assign fl.level_sel = {{(scm_pkg::SCM_NFLAG - scm_pkg::SCM_TRIG_W){1'b1}},
                           trig_ff}; // see [R12] [R13] [R14]

    assign fl.clr = wr_pend ? (reg_wdata[14:0] & scm_pkg::SCM_FLAG_MASK)
                            : 15'h0000; // see [R16]

    scm_flag_bank u_bank (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .fl      (fl)
    );

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            en_ff <= scm_pkg::SCM_EN_RST;
        else if (wr_en)
            en_ff <= reg_wdata[14:0] & scm_pkg::SCM_FLAG_MASK; // see [R11]
    end

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            trig_ff <= scm_pkg::SCM_TRIG_RST;
        else if (wr_trig)
            trig_ff <= reg_wdata[2:0]; // see [R12] [R13] [R14]
    end

    // Mode is meant to be written last, after all other setup
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            mode_ff <= scm_pkg::SCM_MODE_RST;
        else if (wr_mode)
            mode_ff <= reg_wdata[1:0]; // see [R6] [R5]
    end

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            flow_ff <= scm_pkg::SCM_FLOW_RST;
        else if (wr_flow)
            flow_ff <= reg_wdata[scm_pkg::SCM_FLOW_BIT];
    end

    // Code 3 is undefined and behaves as disabled
    assign uart_enable = (mode_ff == scm_pkg::SCM_MODE_UART); // see [R6]
    assign spi_enable  = (mode_ff == scm_pkg::SCM_MODE_SPI);  // see [R6]

    always_comb
    begin
        rd_mux = 32'h0000_0000;
        unique case (sel)
            scm_pkg::SCM_SEL_PEND: rd_mux = {17'h0_0000, fl.flag};
            scm_pkg::SCM_SEL_EN:   rd_mux = {17'h0_0000, en_ff};
            scm_pkg::SCM_SEL_TRIG: rd_mux = {29'h0000_0000, trig_ff};
            scm_pkg::SCM_SEL_MODE: rd_mux = {30'h0000_0000, mode_ff};
            scm_pkg::SCM_SEL_FLOW: rd_mux = {31'h0000_0000, flow_ff};
            scm_pkg::SCM_SEL_NONE: rd_mux = 32'h0000_0000;
        endcase
    end

    // Data only in the cycle after the strobe, zero otherwise
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            rdata_ff <= 32'h0000_0000;
        else if (reg_rd)
            rdata_ff <= rd_mux;
        else
            rdata_ff <= 32'h0000_0000;
    end
    assign reg_rdata = rdata_ff;

    // Registered so the line never glitches on a same-cycle set and clear
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            irq_ff <= 1'b0;
        else
            irq_ff <= |(fl.flag & en_ff); // see [R11]
    end
    assign serial_irq = irq_ff;

    assign flow_on = uart_enable && flow_ff;

    // RTS idles high and undriven unless UART flow control is on
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rts_n_ff  <= 1'b1;
            rts_oe_ff <= 1'b0;
        end
        else
        begin
            rts_n_ff  <= flow_on ? ~uart_rts_req : 1'b1; // see [R15]
            rts_oe_ff <= flow_on;                        // see [R15]
        end
    end
    assign uart_rts_n_out = rts_n_ff;
    assign uart_rts_oe    = rts_oe_ff;

    // CTS is ignored unless flow control is on
    assign uart_tx_permit = !flow_on || !uart_cts_n_in; // see [R15]

    mode_write_a: assert property ( // see [R6]
        @(posedge clk_sys) disable iff (sys_rst)
        wr_mode |=> (mode_ff == $past(reg_wdata[1:0])))
        else $error("mode field did not take written value");

    spi_select_a: assert property ( // see [R6]
        @(posedge clk_sys) disable iff (sys_rst)
        (wr_mode && reg_wdata[1:0] == 2'h2) |=> (spi_enable && !uart_enable))
        else $error("mode 2 did not select SPI");

    parity_set_a: assert property ( // see [R7]
        @(posedge clk_sys) disable iff (sys_rst)
        (parity_fault_flag || framing_fault_flag)
        |=> (fl.flag[14] || fl.flag[13]))
        else $error("UART error did not raise its flag");

    dma_flag_a: assert property ( // see [R8]
        @(posedge clk_sys) disable iff (sys_rst)
        tx_dma_buf_b_done ##0 rx_dma_buf_a_done [*1] |=> (fl.flag[12] && fl.flag[9]))
        else $error("DMA unload flags not raised");

    overrun_set_a: assert property ( // see [R9]
        @(posedge clk_sys) disable iff (sys_rst)
        rx_overrun_flag |=> fl.flag[3] ##1 (fl.flag[3] || $past(fl.clr[3])))
        else $error("overrun flag not raised or lost");

    rx_level_a: assert property ( // see [R12]
        @(posedge clk_sys) disable iff (sys_rst)
        (trig_ff[0] && rx_has_byte_flag && wr_pend) |=> fl.flag[0])
        else $error("level receive flag not refired");

    quiet_edge_a: assert property ( // see [R14]
        @(posedge clk_sys) disable iff (sys_rst)
        (!trig_ff[2] && $rose(tx_quiet_flag)) |=> fl.flag[2])
        else $error("idle edge did not set flag");

    irq_gate_a: assert property ( // see [R11]
        @(posedge clk_sys) disable iff (sys_rst)
        ((fl.flag & en_ff) == 15'h0000) |=> !serial_irq)
        else $error("interrupt raised with no enabled flag");

    irq_raise_a: assert property ( // see [R11]
        @(posedge clk_sys) disable iff (sys_rst)
        (en_ff[4] && fl.flag[4]) |=> serial_irq)
        else $error("enabled flag did not raise interrupt");

    rts_idle_a: assert property ( // see [R15]
        @(posedge clk_sys) disable iff (sys_rst)
        !(uart_enable && flow_ff) |=> (uart_rts_n_out && !uart_rts_oe))
        else $error("RTS driven without flow control");

    read_zero_a: assert property ( // see [R11]
        @(posedge clk_sys) disable iff (sys_rst)
        (reg_rd && sel == scm_pkg::SCM_SEL_PEND) |=> (reg_rdata[8:5] == 4'h0))
        else $error("reserved flag bits read nonzero");

    // Each source but tx_dma_buf_b_done and rx_dma_buf_a_done is watched alone at its own position so a swapped bit shows up
    parity_bit_a: assert property ( // see [R7]
        @(posedge clk_sys) disable iff (sys_rst)
        parity_fault_flag |=> fl.flag[scm_pkg::SCM_BIT_PARITY])
        else $error("parity error flag not raised");

    frame_set_a: assert property ( // see [R7]
        @(posedge clk_sys) disable iff (sys_rst)
        framing_fault_flag |=> fl.flag[scm_pkg::SCM_BIT_FRAME])
        else $error("framing error flag not raised");

    dma_txa_a: assert property ( // see [R8]
        @(posedge clk_sys) disable iff (sys_rst)
        tx_dma_buf_a_done |=> fl.flag[scm_pkg::SCM_BIT_TXA])
        else $error("transmit buffer A flag not raised");

    dma_rxb_a: assert property ( // see [R8]
        @(posedge clk_sys) disable iff (sys_rst)
        rx_dma_buf_b_done |=> fl.flag[scm_pkg::SCM_BIT_RXB])
        else $error("receive buffer B flag not raised");

    underrun_set_a: assert property ( // see [R9]
        @(posedge clk_sys) disable iff (sys_rst)
        tx_underrun_flag |=> fl.flag[scm_pkg::SCM_BIT_UNDER])
        else $error("underrun flag not raised");

    uart_select_a: assert property ( // see [R6]
        @(posedge clk_sys) disable iff (sys_rst)
        (wr_mode && reg_wdata[1:0] == scm_pkg::SCM_MODE_UART) |=> (uart_enable && !spi_enable))
        else $error("mode 1 did not select UART");

    mode_off_a: assert property ( // see [R6]
        @(posedge clk_sys) disable iff (sys_rst)
        (wr_mode && (reg_wdata[1:0] != scm_pkg::SCM_MODE_UART)
                 && (reg_wdata[1:0] != scm_pkg::SCM_MODE_SPI))
        |=> (!uart_enable && !spi_enable))
        else $error("disabled mode left a function selected");

    rx_edge_a: assert property ( // see [R12]
        @(posedge clk_sys) disable iff (sys_rst)
        (!trig_ff[0] && $rose(rx_has_byte_flag)) |=> fl.flag[scm_pkg::SCM_BIT_RXBYTE])
        else $error("receive edge did not set flag");

    space_edge_a: assert property ( // see [R13]
        @(posedge clk_sys) disable iff (sys_rst)
        (!trig_ff[1] && $rose(tx_space_flag)) |=> fl.flag[scm_pkg::SCM_BIT_SPACE])
        else $error("space edge did not set flag");

    quiet_level_a: assert property ( // see [R14]
        @(posedge clk_sys) disable iff (sys_rst)
        (trig_ff[2] && tx_quiet_flag) |=> fl.flag[scm_pkg::SCM_BIT_QUIET])
        else $error("idle level did not set flag");

    enable_write_a: assert property ( // see [R11]
        @(posedge clk_sys) disable iff (sys_rst)
        wr_en |=> (en_ff == ($past(reg_wdata[14:0]) & scm_pkg::SCM_FLAG_MASK)))
        else $error("enable register did not take written value");

    rts_drive_a: assert property ( // see [R15]
        @(posedge clk_sys) disable iff (sys_rst)
        flow_on |=> (uart_rts_oe && (uart_rts_n_out == !$past(uart_rts_req))))
        else $error("RTS not driven under flow control");

    pend_clear_a: assert property ( // see [R16]
        @(posedge clk_sys) disable iff (sys_rst)
        (wr_pend && reg_wdata[scm_pkg::SCM_BIT_UNDER] && !tx_underrun_flag)
        |=> !fl.flag[scm_pkg::SCM_BIT_UNDER])
        else $error("underrun flag not cleared by write one");
endmodule
`default_nettype wire

// *** tb/scm_serial_irq_bench.sv ***
// Purpose: Self-checking bench for the serial mode and interrupt block
// Assumes: Register port with one-cycle strobes and read data one cycle later
// Notes:   Strobes leave a one-cycle gap so no signal is driven twice in one step
`timescale 1ns/10ps
`default_nettype none
module scm_serial_irq_bench;
    typedef struct packed {logic [16:0] src; logic [31:0] pend;} scm_row_t;
    logic        clk_sys   = 1'b0;
    logic        sys_rst   = 1'b1;
    logic [31:0] reg_addr  = 32'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr    = 1'b0;
    logic        reg_rd    = 1'b0;
    logic [16:0] cmd       = 17'h0;
    logic [31:0] reg_rdata;
    logic        uart_enable, spi_enable, uart_rts_n_out, uart_rts_oe, uart_tx_permit, serial_irq;
    wire logic   parity_fault_flag, framing_fault_flag, tx_dma_buf_b_done, tx_dma_buf_a_done;
    wire logic   rx_dma_buf_b_done, rx_dma_buf_a_done, tx_underrun_flag, rx_overrun_flag;
    wire logic   tx_quiet_flag, tx_space_flag, rx_has_byte_flag, uart_rts_req, uart_cts_n_in;
    int          n_mismatch = 0;
    int          checked    = 0;
    scm_row_t    rows [12]  = '{'{17'h04000, 32'h4000}, '{17'h02000, 32'h2000},
        '{17'h01000, 32'h1000}, '{17'h00800, 32'h0800}, '{17'h00400, 32'h0400},
        '{17'h00200, 32'h0200}, '{17'h00010, 32'h0010}, '{17'h00008, 32'h0008},
        '{17'h00004, 32'h0004}, '{17'h00002, 32'h0002}, '{17'h00001, 32'h0001},
        '{17'h07e1f, 32'h7e1f}};

    always #5 clk_sys = ~clk_sys;

    scm_src_model SRC (.cmd, .parity_fault_flag, .framing_fault_flag, .tx_dma_buf_b_done,
        .tx_dma_buf_a_done, .rx_dma_buf_b_done, .rx_dma_buf_a_done, .tx_underrun_flag,
        .rx_overrun_flag, .tx_quiet_flag, .tx_space_flag, .rx_has_byte_flag, .uart_rts_req,
        .uart_cts_n_in);

    scm_serial_irq DUT (.clk_sys, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .parity_fault_flag, .framing_fault_flag, .tx_dma_buf_b_done,
        .tx_dma_buf_a_done, .rx_dma_buf_b_done, .rx_dma_buf_a_done, .tx_underrun_flag,
        .rx_overrun_flag, .tx_quiet_flag, .tx_space_flag, .rx_has_byte_flag, .uart_enable,
        .spi_enable, .uart_rts_req, .uart_cts_n_in, .uart_rts_n_out, .uart_rts_oe,
        .uart_tx_permit, .serial_irq);

    task automatic complete_run();
        $display("Comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk1(input string what, input logic exp, input logic got);
        chk32(what, {31'h0, exp}, {31'h0, got});
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
    endtask

    // Samples read data only in the cycle after the strobe, where it stands
    task automatic rd(input logic [31:0] a, input logic [31:0] exp, input string what);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        #1;
        chk32(what, exp, reg_rdata);
    endtask

    // Parameters first, mode last, then let the registered pins settle
    task automatic flow_case(input logic [1:0] m, input logic f, input logic [1:0] rc,
                             input logic [2:0] exp);
        wr(scm_pkg::SCM_FLOW_ADDR, {31'h0, f});
        wr(scm_pkg::SCM_MODE_ADDR, {30'h0, m});
        @(posedge clk_sys);
        cmd[16:15] <= rc;
        repeat (2) @(posedge clk_sys);
        #1;
        chk32("flow", 32'(exp), {29'h0, uart_rts_oe, uart_rts_n_out, uart_tx_permit});
    endtask

    initial
    begin
        #200000;
        n_mismatch++;
        $display("Error watchdog expected finish seen hang");
        complete_run();
    end

    initial
    begin
        repeat (5) @(posedge clk_sys);
        sys_rst <= 1'b0;
        foreach (rows[i])
        begin
            @(posedge clk_sys);
            cmd <= rows[i].src;
            @(posedge clk_sys);
            cmd <= 17'h0;
            rd(scm_pkg::SCM_PEND_ADDR, rows[i].pend, "pending");
            chk1("irq masked", 1'b0, serial_irq);
            wr(scm_pkg::SCM_EN_ADDR, rows[i].pend);
            rd(scm_pkg::SCM_EN_ADDR, rows[i].pend, "enable");
            chk1("irq enabled", 1'b1, serial_irq);
            wr(scm_pkg::SCM_PEND_ADDR, rows[i].pend);
            wr(scm_pkg::SCM_EN_ADDR, 32'h0);
            rd(scm_pkg::SCM_PEND_ADDR, 32'h0, "cleared");
            chk1("irq idle", 1'b0, serial_irq);
        end
        $display("Test flag rows done");
        rd(scm_pkg::SCM_TRIG_ADDR, 32'h0, "trigger reset");
        wr(32'h4000a80c, 32'hffffffff);
        rd(32'h4000a80c, 32'h0, "unmapped");
        for (int m = 0; m < 4; m++)
        begin
            wr(scm_pkg::SCM_MODE_ADDR, 32'(m));
            rd(scm_pkg::SCM_MODE_ADDR, 32'(m), "mode");
            chk1("uart_enable", m == 1, uart_enable);
            chk1("spi_enable", m == 2, spi_enable);
        end
        wr(scm_pkg::SCM_MODE_ADDR, 32'hffffffff);
        rd(scm_pkg::SCM_MODE_ADDR, 32'h3, "mode width");
        $display("Test mode done");
        // Source held high: edge mode must not refire, level mode must
        for (int b = 0; b < 3; b++)
        begin
            @(posedge clk_sys);
            cmd <= 17'h1 << b;
            wr(scm_pkg::SCM_PEND_ADDR, 32'h1 << b);
            rd(scm_pkg::SCM_PEND_ADDR, 32'h0, "edge once");
            wr(scm_pkg::SCM_TRIG_ADDR, 32'h1 << b);
            wr(scm_pkg::SCM_PEND_ADDR, 32'h1 << b);
            rd(scm_pkg::SCM_PEND_ADDR, 32'h1 << b, "level refire");
            @(posedge clk_sys);
            cmd <= 17'h0;
            wr(scm_pkg::SCM_TRIG_ADDR, 32'h0);
            wr(scm_pkg::SCM_PEND_ADDR, 32'h1 << b);
            rd(scm_pkg::SCM_PEND_ADDR, 32'h0, "level gone");
        end
        $display("Test trigger done");
        @(posedge clk_sys);
        cmd <= 17'h10;
        @(posedge clk_sys);
        cmd <= 17'h0;
        @(posedge clk_sys);
        reg_addr  <= scm_pkg::SCM_PEND_ADDR;
        reg_wdata <= 32'h10;
        reg_wr    <= 1'b1;
        cmd       <= 17'h10;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
        cmd       <= 17'h0;
        rd(scm_pkg::SCM_PEND_ADDR, 32'h10, "set wins");
        wr(scm_pkg::SCM_PEND_ADDR, 32'h0);
        rd(scm_pkg::SCM_PEND_ADDR, 32'h10, "write zero");
        @(posedge clk_sys);
        #1;
        chk32("rdata idle", 32'h0, reg_rdata);
        $display("Test clear done");
        flow_case(2'h1, 1'b1, 2'b11, 3'b100);
        flow_case(2'h1, 1'b1, 2'b01, 3'b101);
        flow_case(2'h1, 1'b0, 2'b10, 3'b011);
        flow_case(2'h2, 1'b1, 2'b11, 3'b011);
        $display("Test flow done");
        wr(scm_pkg::SCM_EN_ADDR, 32'h10);
        @(posedge clk_sys);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        #1;
        chk1("irq in reset", 1'b0, serial_irq);
        chk1("spi in reset", 1'b0, spi_enable);
        @(posedge clk_sys);
        sys_rst <= 1'b0;
        rd(scm_pkg::SCM_MODE_ADDR, 32'h0, "mode reset");
        rd(scm_pkg::SCM_PEND_ADDR, 32'h0, "pending reset");
        rd(scm_pkg::SCM_EN_ADDR, 32'h0, "enable reset");
        rd(scm_pkg::SCM_FLOW_ADDR, 32'h0, "flow reset");
        $display("Test reset done");
        complete_run();
    end
endmodule
`default_nettype wire

// *** tb/scm_src_model.sv ***
// Purpose: Stands in for the serial core, DMA and flow pins around the interrupt block
// Assumes: The bench changes the command just after a rising clk_sys edge
// Notes:   Command bit k feeds flag position k; bit 15 is the RTS request, bit 16 the CTS pin
`timescale 1ns/10ps
`default_nettype none
module scm_src_model (
    // Command from the bench
    input  wire logic [16:0] cmd,
    // Error and DMA events
    output logic             parity_fault_flag,
    output logic             framing_fault_flag,
    output logic             tx_dma_buf_b_done,
    output logic             tx_dma_buf_a_done,
    output logic             rx_dma_buf_b_done,
    output logic             rx_dma_buf_a_done,
    output logic             tx_underrun_flag,
    output logic             rx_overrun_flag,
    // Buffer conditions
    output logic             tx_quiet_flag,
    output logic             tx_space_flag,
    output logic             rx_has_byte_flag,
    // Flow control
    output logic             uart_rts_req,
    output logic             uart_cts_n_in
);
    // Unused command bits 8..5 have no source, matching the empty flag positions
    assign parity_fault_flag  = cmd[14];
    assign framing_fault_flag = cmd[13];
    assign tx_dma_buf_b_done  = cmd[12];
    assign tx_dma_buf_a_done  = cmd[11];
    assign rx_dma_buf_b_done  = cmd[10];
    assign rx_dma_buf_a_done  = cmd[9];
    assign tx_underrun_flag   = cmd[4];
    assign rx_overrun_flag    = cmd[3];
    assign tx_quiet_flag      = cmd[2];
    assign tx_space_flag      = cmd[1];
    assign rx_has_byte_flag   = cmd[0];
    assign uart_rts_req       = cmd[15];
    assign uart_cts_n_in      = cmd[16];
endmodule
`default_nettype wire
